// file: tmc_pkg.sv
// Purpose: Shared constants and types of the timer channel mode control.
// Assumes: 32-bit AXI4-Lite data, 4-bit byte address, one word a register.
// Notes:   All offsets, field positions and reset values live here.

`default_nettype none

package tmc_pkg;

   // -------------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------------
   localparam int          TMC_AW         = 4;
   localparam logic [3:0]  TMC_OFF_UPPER  = 4'h0;
   localparam logic [3:0]  TMC_OFF_LOWER  = 4'h4;
   localparam logic [3:0]  TMC_OFF_CTRL   = 4'h8;
   localparam logic [3:0]  TMC_OFF_STATUS = 4'hC;
   localparam logic [7:0]  TMC_RST_UPPER  = 8'h00;
   localparam logic [7:0]  TMC_RST_LOWER  = 8'h00;
   // Writable bits; reserved bits are stored as zero.
   localparam logic [7:0]  TMC_MASK_UPPER = 8'h9F;
   localparam logic [7:0]  TMC_MASK_LOWER = 8'hCF;

   // -------------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------------
   localparam int TMC_UP_CKS    = 7;
   localparam int TMC_UP_CCS    = 4;
   localparam int TMC_UP_SPLIT  = 3;
   localparam int TMC_UP_STS    = 0;
   localparam int TMC_LO_CIS    = 6;
   localparam int TMC_LO_MD     = 1;
   localparam int TMC_LO_OPT    = 0;
   localparam int TMC_CT_START  = 0;
   localparam int TMC_CT_STOP   = 1;
   localparam int TMC_ST_RUN    = 0;
   localparam int TMC_ST_UP     = 1;
   localparam int TMC_ST_SPLIT  = 2;
   localparam int TMC_ST_ACT_UP = 8;
   localparam int TMC_ST_ACT_LO = 16;

   // -------------------------------------------------------------------
   // Encodings
   // -------------------------------------------------------------------
   localparam logic [2:0] TMC_TRG_SW      = 3'h0;
   localparam logic [2:0] TMC_TRG_EDGE    = 3'h1;
   localparam logic [2:0] TMC_TRG_BOTH    = 3'h2;
   localparam logic [2:0] TMC_TRG_MST     = 3'h4;
   localparam logic [2:0] TMC_TRG_MST_END = 3'h6;
   localparam logic [2:0] TMC_MD_INTV     = 3'h0;
   localparam logic [2:0] TMC_MD_CAPT     = 3'h2;
   localparam logic [2:0] TMC_MD_EVNT     = 3'h3;
   localparam logic [2:0] TMC_MD_ONE      = 3'h4;
   localparam logic [2:0] TMC_MD_CAPONE   = 3'h6;
   localparam logic [1:0] TMC_EDG_FALL    = 2'h0;
   localparam logic [1:0] TMC_EDG_RISE    = 2'h1;
   localparam logic [1:0] TMC_EDG_LOW_W   = 2'h2;
   localparam logic [1:0] TMC_EDG_HIGH_W  = 2'h3;
   localparam logic [1:0] TMC_RESP_OKAY   = 2'h0;
   localparam logic [1:0] TMC_RESP_SLVERR = 2'h2;

   typedef enum logic {TMC_IDLE, TMC_RUN} tmc_run_type;

endpackage : tmc_pkg

`default_nettype wire

// file: tmc_edge_if.sv
// Purpose: Carries one-cycle pin edge events between the channel modules.
// Assumes: Both ends run on the same clock.
// Notes:   Each signal is high for one clock when its edge was seen.

`timescale 1ns/1ps
`default_nettype none

interface tmc_edge_if;
   logic ti_rise;
   logic ti_fall;
   logic end_rise;
   logic end_fall;
   modport src (output ti_rise, output ti_fall,
                output end_rise, output end_fall);
   modport dst (input ti_rise, input ti_fall,
                input end_rise, input end_fall);
endinterface : tmc_edge_if

`default_nettype wire

// file: tmc_edge.sv
// Purpose: Finds rising and falling edges on the two timer input pins.
// Assumes: Pins are synchronous to aclk.
// Notes:   No edge is reported until one sample has been taken.

`timescale 1ns/1ps
`default_nettype none

module tmc_edge
   import tmc_pkg::*;
(
   // Clock, reset and enable
   input  wire logic   aclk,
   input  wire logic   aresetn,
   input  wire logic   ce,
   // Pins
   input  wire logic   channel_timer_input,
   input  wire logic   end_trigger_input,
   // Edge events
   tmc_edge_if.src     e
);

   typedef struct packed {
      logic seen;
      logic ti;
      logic en;
   } tmc_edge_state_type;

   tmc_edge_state_type r;
   tmc_edge_state_type n;

   // -------------------------------------------------------------------
   // Sampling
   // -------------------------------------------------------------------
   // The seen bit keeps a pin that is high at reset from faking a rise.
   always_comb begin
      n      = r;
      n.seen = 1'b1;
      n.ti   = channel_timer_input;
      n.en   = end_trigger_input;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '0;
      end else if (ce) begin
         r <= n;
      end
   end

   // Edges are combinational from the pin and the last sample.
   assign e.ti_rise  = ce & r.seen & channel_timer_input & ~r.ti;
   assign e.ti_fall  = ce & r.seen & ~channel_timer_input & r.ti;
   assign e.end_rise = ce & r.seen & end_trigger_input & ~r.en;
   assign e.end_fall = ce & r.seen & ~end_trigger_input & r.en;

endmodule : tmc_edge

`default_nettype wire

// file: tmc_channel.sv
// Purpose: Mode control of one timer channel with an AXI4-Lite register
//          slave: clock, width, trigger, edge and counting mode choice.
// Assumes: One clock; pins and prescaler ticks synchronous to aclk.
// Notes:   The counter itself lives outside; it reports count_done.

`timescale 1ns/1ps
`default_nettype none

module tmc_channel
   import tmc_pkg::*;
(
   // Clock, reset and enable
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              ce,
   // AXI4-Lite write address and data
   input  wire logic [TMC_AW-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read
   input  wire logic [TMC_AW-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Timer sources
   input  wire logic              prescaled_clock_a,
   input  wire logic              prescaled_clock_b,
   input  wire logic              channel_timer_input,
   input  wire logic              end_trigger_input,
   input  wire logic              master_channel_irq,
   input  wire logic              count_done,
   // Channel controls
   output logic                   channel_op_clock,
   output logic                   channel_count_clock,
   output logic                   count_up,
   output logic                   split_8bit,
   output logic                   running,
   output logic                   start_pulse,
   output logic                   capture_pulse,
   output logic                   end_pulse,
   output logic                   timer_irq,
   output logic                   output_toggle
);

   typedef struct packed {
      logic              aw_held;
      logic [TMC_AW-1:0] aw_addr;
      logic              w_held;
      logic [31:0]       w_data;
      logic [3:0]        w_strb;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
      logic [7:0]        upper;
      logic [7:0]        lower;
      logic [7:0]        act_up;
      logic [7:0]        act_lo;
      tmc_run_type       run;
      logic              sw_start;
      logic              sw_stop;
      logic              op_tick;
      logic              cnt_tick;
      logic              start_p;
      logic              capt_p;
      logic              end_p;
      logic              irq_p;
      logic              out_tgl;
   } tmc_state_type;

   localparam tmc_state_type TMC_RST = '{
      upper   : TMC_RST_UPPER,
      lower   : TMC_RST_LOWER,
      act_up  : TMC_RST_UPPER,
      act_lo  : TMC_RST_LOWER,
      run     : TMC_IDLE,
      default : '0
   };

   tmc_state_type r;
   tmc_state_type n;
   tmc_edge_if    edg ();

   // -------------------------------------------------------------------
   // Functions
   // -------------------------------------------------------------------
   // Valid pin edge for the start (cap=0) or capture/end (cap=1) role.
   function automatic logic valid_edge(input logic [1:0] cis,
                                       input logic       rise,
                                       input logic       fall,
                                       input logic       cap);
      logic v;
      v = 1'b0;
      case (cis)
         TMC_EDG_FALL:   v = fall;
         TMC_EDG_RISE:   v = rise;
         TMC_EDG_LOW_W:  v = cap ? rise : fall;
         TMC_EDG_HIGH_W: v = cap ? fall : rise;
         default:        v = 1'b0;
      endcase
      return v;
   endfunction : valid_edge

   // Known mode codes; a stray code keeps the channel from starting.
   function automatic logic mode_ok(input logic [2:0] md,
                                    input logic       opt);
      logic v;
      v = 1'b0;
      case (md)
         TMC_MD_INTV:   v = 1'b1;
         TMC_MD_CAPT:   v = 1'b1;
         TMC_MD_EVNT:   v = ~opt;
         TMC_MD_ONE:    v = 1'b1;
         TMC_MD_CAPONE: v = ~opt;
         default:       v = 1'b0;
      endcase
      return v;
   endfunction : mode_ok

   // Capture and capture one-count count up; all others count down.
   function automatic logic mode_up(input logic [2:0] md);
      return (md == TMC_MD_CAPT) || (md == TMC_MD_CAPONE);
   endfunction : mode_up

   // -------------------------------------------------------------------
   // Pin edge detection
   // -------------------------------------------------------------------
   tmc_edge u_edge (
      .aclk                (aclk),
      .aresetn             (aresetn),
      .ce                  (ce),
      .channel_timer_input (channel_timer_input),
      .end_trigger_input   (end_trigger_input),
      .e                   (edg)
   );

   // -------------------------------------------------------------------
   // Decoded active selection
   // -------------------------------------------------------------------
   logic [2:0] md;
   logic       opt;
   logic [2:0] trg;
   logic [1:0] cis;
   logic       edge_st;
   logic       edge_cp;
   logic       hw_start;
   logic       capt_ev;
   logic       end_ev;
   logic       start_irq;

   // Field slices of the selection the channel is running with.
   assign md      = r.act_lo[TMC_LO_MD +: 3];
   assign opt     = r.act_lo[TMC_LO_OPT];
   assign trg     = r.act_up[TMC_UP_STS +: 3];
   assign cis     = r.act_lo[TMC_LO_CIS +: 2];
   assign edge_st = valid_edge(cis, edg.ti_rise, edg.ti_fall, 1'b0);
   assign edge_cp = valid_edge(cis, edg.ti_rise, edg.ti_fall, 1'b1);

   // Start interrupt only in interval or capture mode with the option.
   // Event and capture one-count modes never raise it.
   assign start_irq = opt & ((md == TMC_MD_INTV) ||
                             (md == TMC_MD_CAPT));

   // Trigger source selection.
   always_comb begin
      hw_start = 1'b0;
      capt_ev  = 1'b0;
      end_ev   = 1'b0;
      case (trg)
         TMC_TRG_SW: begin
            hw_start = 1'b0;
         end
         TMC_TRG_EDGE: begin
            hw_start = edge_st;
            capt_ev  = edge_cp;
         end
         TMC_TRG_BOTH: begin
            hw_start = edg.ti_rise | edg.ti_fall;
            capt_ev  = edg.ti_rise | edg.ti_fall;
         end
         TMC_TRG_MST: begin
            hw_start = master_channel_irq;
         end
         TMC_TRG_MST_END: begin
            hw_start = master_channel_irq;
            end_ev   = valid_edge(cis, edg.end_rise,
                                  edg.end_fall, 1'b1);
         end
         default: begin
            hw_start = 1'b0;
         end
      endcase
   end

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------
   always_comb begin
      n          = r;
      n.sw_start = 1'b0;
      n.sw_stop  = 1'b0;
      n.start_p  = 1'b0;
      n.capt_p   = 1'b0;
      n.end_p    = 1'b0;
      n.irq_p    = 1'b0;
      n.out_tgl  = 1'b0;
      n.cnt_tick = 1'b0;

      // Address and data are taken in either order and held.
      if (s_axi_awvalid && s_axi_awready) begin
         n.aw_held = 1'b1;
         n.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         n.w_held = 1'b1;
         n.w_data = s_axi_wdata;
         n.w_strb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
      end

      // Both halves held: perform the write and raise the response.
      if (r.aw_held && r.w_held) begin
         n.aw_held = 1'b0;
         n.w_held  = 1'b0;
         n.bvalid  = 1'b1;
         n.bresp   = TMC_RESP_OKAY;
         case (r.aw_addr)
            TMC_OFF_UPPER: begin
               if (r.w_strb[0]) begin
                  n.upper = r.w_data[7:0] & TMC_MASK_UPPER;
               end
            end
            TMC_OFF_LOWER: begin
               if (r.w_strb[0]) begin
                  n.lower = r.w_data[7:0] & TMC_MASK_LOWER;
               end
            end
            TMC_OFF_CTRL: begin
               if (r.w_strb[0]) begin
                  n.sw_start = r.w_data[TMC_CT_START];
                  n.sw_stop  = r.w_data[TMC_CT_STOP];
               end
            end
            TMC_OFF_STATUS: begin
               n.bresp = TMC_RESP_OKAY;    // Read-only; write dropped.
            end
            default: begin
               n.bresp = TMC_RESP_SLVERR;
            end
         endcase
      end

      // Reads answer one cycle after the address is taken.
      if (s_axi_rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         n.rvalid = 1'b1;
         n.rresp  = TMC_RESP_OKAY;
         n.rdata  = '0;
         case (s_axi_araddr)
            TMC_OFF_UPPER:  n.rdata[7:0] = r.upper;
            TMC_OFF_LOWER:  n.rdata[7:0] = r.lower;
            TMC_OFF_CTRL:   n.rdata      = '0;
            TMC_OFF_STATUS: begin
               n.rdata[TMC_ST_RUN]        = (r.run == TMC_RUN);
               n.rdata[TMC_ST_UP]         = mode_up(md);
               n.rdata[TMC_ST_SPLIT]      = r.act_up[TMC_UP_SPLIT];
               n.rdata[TMC_ST_ACT_UP +: 8] = r.act_up;
               n.rdata[TMC_ST_ACT_LO +: 8] = r.act_lo;
            end
            default:        n.rresp      = TMC_RESP_SLVERR;
         endcase
      end

      // Operation clock tick picked from the two prescaler outputs.
      n.op_tick = r.act_up[TMC_UP_CKS] ? prescaled_clock_b
                                       : prescaled_clock_a;

      // Channel sequencing.
      case (r.run)
         TMC_IDLE: begin
            // Stopped: the programmed selection is copied in freely.
            n.act_up = r.upper;
            n.act_lo = r.lower;
            if ((r.sw_start || hw_start) && mode_ok(md, opt)) begin
               n.run     = TMC_RUN;
               n.start_p = 1'b1;
               n.irq_p   = start_irq;
               n.out_tgl = start_irq;
            end
         end
         TMC_RUN: begin
            // Count clock: op clock tick or valid timer input edge.
            n.cnt_tick = r.act_up[TMC_UP_CCS] ? edge_st
                                              : r.op_tick;
            if (r.sw_stop) begin
               n.run = TMC_IDLE;
            end else if (end_ev) begin
               n.run   = TMC_IDLE;
               n.end_p = 1'b1;
            end else if (count_done && (md == TMC_MD_ONE ||
                                        md == TMC_MD_CAPONE)) begin
               n.run   = TMC_IDLE;
               n.end_p = 1'b1;
            end else if (capt_ev && md == TMC_MD_CAPONE) begin
               // Width measured: capture and stop in one go.
               n.capt_p = 1'b1;
               n.end_p  = 1'b1;
               n.run    = TMC_IDLE;
            end else begin
               if (capt_ev && md == TMC_MD_CAPT) begin
                  n.capt_p = 1'b1;
               end
               case (md)
                  TMC_MD_ONE: begin
                     // Retrigger only when the option allows it.
                     if ((r.sw_start || hw_start) && opt) begin
                        n.start_p = 1'b1;
                        n.irq_p   = 1'b1;
                     end
                  end
                  TMC_MD_CAPONE: begin
                     n.start_p = 1'b0;
                  end
                  default: begin
                     // Free-running modes restart only by software,
                     // since a pin edge here means capture.
                     if (r.sw_start) begin
                        n.start_p = 1'b1;
                        n.irq_p   = start_irq;
                        n.out_tgl = start_irq;
                     end
                  end
               endcase
            end
         end
         default: begin
            n.run = TMC_IDLE;
         end
      endcase
   end

   // -------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------
   // A low clock enable freezes everything, bus side included.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= TMC_RST;
      end else if (ce) begin
         r <= n;
      end
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   // Readies drop with the clock enable so no beat is lost.
   assign s_axi_awready = ce & ~r.aw_held & ~r.bvalid;
   assign s_axi_wready  = ce & ~r.w_held & ~r.bvalid;
   assign s_axi_arready = ce & ~r.rvalid;
   assign s_axi_bvalid  = r.bvalid;
   assign s_axi_bresp   = r.bresp;
   assign s_axi_rvalid  = r.rvalid;
   assign s_axi_rdata   = r.rdata;
   assign s_axi_rresp   = r.rresp;

   // Channel controls straight from flip-flops, except count_up, which is decoded from the active mode bits.
   assign channel_op_clock    = r.op_tick;
   assign channel_count_clock = r.cnt_tick;
   assign count_up            = mode_up(md);
   assign split_8bit          = r.act_up[TMC_UP_SPLIT];
   assign running             = (r.run == TMC_RUN);
   assign start_pulse         = r.start_p;
   assign capture_pulse       = r.capt_p;
   assign end_pulse           = r.end_p;
   assign timer_irq           = r.irq_p;
   assign output_toggle       = r.out_tgl;

endmodule : tmc_channel

`default_nettype wire

// file: tmc_channel_chk.sv
// Purpose: Port-level checks of the timer channel mode control.
// Assumes: Clock enable held high by the bench.
// Notes:   Bound to every instance of the channel.
`timescale 1ns/1ps
`default_nettype none
module tmc_channel_chk (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus handshakes
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Timer side
   input wire logic prescaled_clock_a,
   input wire logic prescaled_clock_b,
   input wire logic channel_op_clock,
   input wire logic running,
   input wire logic start_pulse,
   input wire logic capture_pulse,
   input wire logic timer_irq,
   input wire logic output_toggle
);
   // One clock domain, so one default clock and reset serve all checks.
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid) else $error("write answer dropped early");
   a_rresp_holds: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid) else $error("read answer dropped early");
   a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("address taken during answer");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken during answer");
   a_irq_at_start: assert property (timer_irq |-> start_pulse)
      else $error("interrupt without start");
   a_toggle_at_start: assert property (output_toggle
      |-> start_pulse && running) else $error("toggle without start");
   a_start_runs: assert property (start_pulse |-> running)
      else $error("start without running");
   a_op_clock_tick: assert property (channel_op_clock
      |-> $past(prescaled_clock_a || prescaled_clock_b))
      else $error("op clock without tick");
   a_capture_running: assert property (capture_pulse
      |-> $past(running)) else $error("capture while idle");
   c_start_irq: cover property (start_pulse && timer_irq);
   c_capture: cover property (capture_pulse);
   c_op_clock: cover property (channel_op_clock);
endmodule : tmc_channel_chk
bind tmc_channel tmc_channel_chk u_chk (.*);
`default_nettype wire

// file: tmc_channel_tb.sv
// Purpose: Self-checking bench of the timer channel mode control.
// Assumes: Bus master and pins driven by non-blocking assignment.
// Notes:   seen holds start, irq, capture, end, op clock of a window;
//          tg holds output toggle and count clock of the same window.
`timescale 1ns/1ps
`default_nettype none
module tmc_channel_tb;
   import tmc_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, count_done = 1'b0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, prescaled_clock_a = 0;
   logic prescaled_clock_b = 0, channel_timer_input = 0;
   logic end_trigger_input = 0, master_channel_irq = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, channel_op_clock, channel_count_clock, count_up;
   logic split_8bit, running, start_pulse, capture_pulse, end_pulse;
   logic timer_irq, output_toggle;
   logic [4:0] seen;
   logic [1:0] tg;
   logic [7:0] mv [5] = '{8'h00, 8'h04, 8'h06, 8'h08, 8'h0C};
   logic [4:0] cu = 5'b10010;
   int miscompares = 0, n_compared = 0, cyc = 0;
   tmc_channel DUT (.*);
   always #20 aclk = ~aclk;
   task end_of_test;
      if (miscompares == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_of_test
   // A hung handshake must not stall the run forever.
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         miscompares++;
         end_of_test;
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   // Address and data are released each on its own ready.
   task wr(input logic [3:0] a, input logic [7:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      @(posedge aclk);
      while (s_axi_awvalid || s_axi_wvalid) begin
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         @(posedge aclk);
      end
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      chk(s_axi_bresp, TMC_RESP_OKAY);
      s_axi_bready <= 1'b0;
   endtask : wr
   task rd(input logic [3:0] a, input logic [31:0] e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      chk(s_axi_rdata, e);
      chk(s_axi_rresp, TMC_RESP_OKAY);
      s_axi_rready <= 1'b0;
   endtask : rd
   task run(input int n);
      seen = 5'h0;
      tg = 2'h0;
      repeat (n) begin
         @(posedge aclk);
         seen |= {start_pulse, timer_irq, capture_pulse, end_pulse,
                  channel_op_clock};
         tg |= {output_toggle, channel_count_clock};
      end
   endtask : run
   // Sets the two pins and gives the master interrupt one cycle.
   task kick(input logic [2:0] v, input logic [4:0] e);
      {channel_timer_input, end_trigger_input, master_channel_irq} <= v;
      @(posedge aclk);
      master_channel_irq <= 1'b0;
      run(4);
      chk(seen, e);
   endtask : kick
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(TMC_OFF_UPPER, 32'h0);
      rd(TMC_OFF_LOWER, 32'h0);
      wr(TMC_OFF_UPPER, 8'hFF);
      rd(TMC_OFF_UPPER, 32'h9F);
      wr(TMC_OFF_LOWER, 8'hFF);
      rd(TMC_OFF_LOWER, 32'hCF);
      chk(split_8bit, 1'b1);
      foreach (mv[i]) begin
         wr(TMC_OFF_LOWER, mv[i]);
         run(2);
         chk(count_up, cu[i]);
      end
      wr(TMC_OFF_UPPER, 8'h00);
      wr(TMC_OFF_LOWER, 8'h01);
      kick(3'b101, 5'b00000);
      wr(TMC_OFF_CTRL, 8'h01);
      run(4);
      chk(seen, 5'b11000);
      chk(tg, 2'b10);
      prescaled_clock_a <= 1'b1;
      @(posedge aclk);
      prescaled_clock_a <= 1'b0;
      run(4);
      chk(tg, 2'b01);
      rd(TMC_OFF_STATUS, 32'h00010001);
      wr(TMC_OFF_LOWER, 8'h05);
      run(2);
      chk(count_up, 1'b0);
      wr(TMC_OFF_CTRL, 8'h02);
      run(3);
      chk(count_up, 1'b1);
      wr(TMC_OFF_UPPER, 8'h01);
      wr(TMC_OFF_LOWER, 8'h44);
      kick(3'b000, 5'b00000);
      kick(3'b100, 5'b10000);
      kick(3'b000, 5'b00000);
      kick(3'b100, 5'b00100);
      wr(TMC_OFF_CTRL, 8'h02);
      wr(TMC_OFF_UPPER, 8'h12);
      kick(3'b000, 5'b10000);
      kick(3'b100, 5'b00100);
      chk(tg, 2'b01);
      wr(TMC_OFF_CTRL, 8'h02);
      wr(TMC_OFF_UPPER, 8'h04);
      wr(TMC_OFF_LOWER, 8'h08);
      kick(3'b001, 5'b10000);
      kick(3'b001, 5'b00000);
      wr(TMC_OFF_CTRL, 8'h02);
      wr(TMC_OFF_LOWER, 8'h09);
      kick(3'b001, 5'b10000);
      kick(3'b001, 5'b11000);
      count_done <= 1'b1;
      @(posedge aclk);
      count_done <= 1'b0;
      run(2);
      chk(seen[1], 1'b1);
      chk(running, 1'b0);
      wr(TMC_OFF_CTRL, 8'h02);
      wr(TMC_OFF_UPPER, 8'h06);
      wr(TMC_OFF_LOWER, 8'h08);
      kick(3'b001, 5'b10000);
      kick(3'b010, 5'b00000);
      kick(3'b000, 5'b00010);
      chk(running, 1'b0);
      wr(TMC_OFF_UPPER, 8'h80);
      for (int i = 1; i < 3; i++) begin
         {prescaled_clock_a, prescaled_clock_b} <= 2'(i);
         @(posedge aclk);
         {prescaled_clock_a, prescaled_clock_b} <= 2'b00;
         run(3);
         chk(seen[0], i[0]);
      end
      end_of_test;
   end
endmodule : tmc_channel_tb
`default_nettype wire
